// File: src/efcb_pkg.sv
`default_nettype none
package efcb_pkg;
	// Register offsets
	localparam logic [7:0] OFF_PAGE_SEL   = 8'h02;
	localparam logic [7:0] OFF_EN_A       = 8'h04;
	localparam logic [7:0] OFF_EN_B       = 8'h05;
	localparam logic [7:0] OFF_PAGE_ADDR  = 8'h08;
	localparam logic [7:0] OFF_PAGE_DATA  = 8'h09;
	localparam logic [7:0] OFF_FUNC_RT    = 8'h0a;
	localparam logic [7:0] OFF_FSM_RT_LO  = 8'h0b;
	localparam logic [7:0] OFF_FSM_RT_HI  = 8'h0c;
	// Field positions
	localparam int SEL_LSB       = 4;
	localparam int SEL_FIXED_BIT = 0;
	localparam int EN_A_SIGMOT   = 5;
	localparam int EN_A_TILT     = 4;
	localparam int EN_A_STEP     = 3;
	localparam int EN_B_ADV      = 4;
	localparam int EN_B_COMPR    = 3;
	localparam int EN_B_FSM      = 0;
	localparam int RT_LC         = 5;
	localparam int RT_TILT       = 4;
	localparam int RT_STEP       = 3;
	// Values after reset
	localparam logic [3:0] RST_SEL  = 4'h0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic       RST_BIT  = 1'b0;
	// Indirect page geometry
	localparam int PAGES      = 16;
	localparam int PAGE_DEPTH = 256;
endpackage : efcb_pkg
`default_nettype wire

// File: src/route_mask_or.sv
`timescale 1ns/1ps
`default_nettype none
module route_mask_or #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] evt_i,
	input  wire logic [W-1:0] mask_i,
	input  wire logic         gate_i,
	output logic              hit_o
);
	if (W < 1) begin : g_bad_w
		$error("route_mask_or: W must be at least 1");
	end

	// Masked OR of the events, held off by the gate
	assign hit_o = gate_i & (|(evt_i & mask_i));
endmodule : route_mask_or
`default_nettype wire

// File: src/page_store.sv
`timescale 1ns/1ps
`default_nettype none
module page_store #(
	parameter int PAGES = efcb_pkg::PAGES,
	parameter int DEPTH = efcb_pkg::PAGE_DEPTH
) (
	input  wire logic       clk_i,
	input  wire logic       ce_i,
	input  wire logic       we_i,
	input  wire logic [3:0] page_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);
	if (PAGES < 1 || PAGES > 16 || DEPTH < 1 || DEPTH > 256) begin : g_bad
		$error("page_store: PAGES 1..16 and DEPTH 1..256 only");
	end

	logic [7:0] mem [PAGES*DEPTH];
	logic [31:0] idx;
	logic        in_range;

	// Flat index of page and address, shared by write and read
	assign idx = 32'(page_i) * 32'(DEPTH) + 32'(addr_i);
	assign in_range = (32'(page_i) < PAGES) && (32'(addr_i) < DEPTH);

	always_ff @(posedge clk_i) begin
		if (ce_i && we_i && in_range) begin
			mem[idx] <= wdata_i;
		end
	end

	assign rdata_o = in_range ? mem[idx] : 8'h00;
endmodule : page_store
`default_nettype wire

// File: src/embedded_function_config_bank.sv
`timescale 1ns/1ps
`default_nettype none
module embedded_function_config_bank #(
	parameter int PAGES      = efcb_pkg::PAGES,
	parameter int PAGE_DEPTH = efcb_pkg::PAGE_DEPTH,
	parameter int MACHINES   = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	output logic             reg_ack_o,
	input  wire logic        function_bank_access_on_i,
	input  wire logic        page_write_i,
	input  wire logic        page_read_i,
	input  wire logic        runtime_compression_allow_i,
	input  wire logic        function_events_route_gate_i,
	input  wire logic        long_timeout_evt_i,
	input  wire logic        incline_evt_i,
	input  wire logic        step_evt_i,
	input  wire logic [15:0] machine_evt_i,
	output logic      [3:0]  page_select_o,
	output logic             sig_motion_on_o,
	output logic             incline_on_o,
	output logic             step_algorithm_on_o,
	output logic             step_false_reject_on_o,
	output logic             buffer_compression_on_o,
	output logic             state_machine_engine_on_o,
	output logic             first_interrupt_pin_o
);
	if (MACHINES != 16) begin : g_bad_machines
		$error("embedded_function_config_bank: MACHINES must be 16");
	end
	if (PAGES < 1 || PAGES > 16 || PAGE_DEPTH < 1 || PAGE_DEPTH > 256)
	begin : g_bad_pages
		$error("embedded_function_config_bank: page geometry too big");
	end

	typedef struct packed {
		logic [3:0] sel;
		logic       sigmot;
		logic       incline;
		logic       step;
		logic       step_adv;
		logic       compr_req;
		logic       state_machine_engine_on;
		logic [7:0] pg_addr;
		logic [7:0] pg_data;
		logic       lc_rt;
		logic       incl_rt;
		logic       step_rt;
		logic [7:0] fsm_rt_lo;
		logic [7:0] fsm_rt_hi;
		logic       compr_on;
		logic       pin;
		logic [7:0] rdata;
		logic       ack;
	} bank_s;

	bank_s q;
	bank_s d;

	logic       rst_meta_q;
	logic       rst_n_q;
	logic       acc_wr;
	logic       acc_rd;
	logic [7:0] mem_rdata;
	logic       mem_we;
	logic       func_hit;
	logic       fsm_hit;

	function automatic logic at(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : at

	// Reset release through two flops
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Accesses only count while the bank is open
	assign acc_wr = reg_wr_i & function_bank_access_on_i;
	assign acc_rd = reg_rd_i & function_bank_access_on_i;

	// Indirect write lands in the selected page
	assign mem_we = acc_wr & at(reg_addr_i, efcb_pkg::OFF_PAGE_DATA)
		& page_write_i;

	page_store #(
		.PAGES (PAGES),
		.DEPTH (PAGE_DEPTH)
	) u_page_store (
		.clk_i   (clk_i),
		.ce_i    (ce_i),
		.we_i    (mem_we),
		.page_i  (q.sel),
		.addr_i  (q.pg_addr),
		.wdata_i (reg_wdata_i),
		.rdata_o (mem_rdata)
	);

	route_mask_or #(
		.W (3)
	) u_func_route (
		.evt_i  ({long_timeout_evt_i, incline_evt_i, step_evt_i}),
		.mask_i ({q.lc_rt, q.incl_rt, q.step_rt}),
		.gate_i (function_events_route_gate_i),
		.hit_o  (func_hit)
	);

	route_mask_or #(
		.W (16)
	) u_fsm_route (
		.evt_i  (machine_evt_i),
		.mask_i ({q.fsm_rt_hi, q.fsm_rt_lo}),
		.gate_i (function_events_route_gate_i),
		.hit_o  (fsm_hit)
	);

	always_comb begin
		d = q;
		d.ack = reg_wr_i | reg_rd_i;
		// Register writes
		if (acc_wr) begin
			case (reg_addr_i)
				efcb_pkg::OFF_PAGE_SEL: begin
					d.sel = reg_wdata_i[efcb_pkg::SEL_LSB +: 4];
				end
				efcb_pkg::OFF_EN_A: begin
					d.sigmot  = reg_wdata_i[efcb_pkg::EN_A_SIGMOT];
					d.incline = reg_wdata_i[efcb_pkg::EN_A_TILT];
					d.step    = reg_wdata_i[efcb_pkg::EN_A_STEP];
				end
				efcb_pkg::OFF_EN_B: begin
					d.step_adv  = reg_wdata_i[efcb_pkg::EN_B_ADV];
					d.compr_req = reg_wdata_i[efcb_pkg::EN_B_COMPR];
					d.state_machine_engine_on    = reg_wdata_i[efcb_pkg::EN_B_FSM];
				end
				efcb_pkg::OFF_PAGE_ADDR: begin
					d.pg_addr = reg_wdata_i;
				end
				efcb_pkg::OFF_PAGE_DATA: begin
					d.pg_data = reg_wdata_i;
				end
				efcb_pkg::OFF_FUNC_RT: begin
					d.lc_rt   = reg_wdata_i[efcb_pkg::RT_LC];
					d.incl_rt = reg_wdata_i[efcb_pkg::RT_TILT];
					d.step_rt = reg_wdata_i[efcb_pkg::RT_STEP];
				end
				efcb_pkg::OFF_FSM_RT_LO: begin
					d.fsm_rt_lo = reg_wdata_i;
				end
				efcb_pkg::OFF_FSM_RT_HI: begin
					d.fsm_rt_hi = reg_wdata_i;
				end
				default: begin
					d.ack = 1'b1;
				end
			endcase
		end
		// Register reads, unassigned bits read zero except page select bit 0, which reads one
		d.rdata = efcb_pkg::RST_BYTE;
		if (acc_rd) begin
			case (reg_addr_i)
				efcb_pkg::OFF_PAGE_SEL: begin
					d.rdata[efcb_pkg::SEL_LSB +: 4] = q.sel;
					d.rdata[efcb_pkg::SEL_FIXED_BIT] = 1'b1;
				end
				efcb_pkg::OFF_EN_A: begin
					d.rdata[efcb_pkg::EN_A_SIGMOT] = q.sigmot;
					d.rdata[efcb_pkg::EN_A_TILT]   = q.incline;
					d.rdata[efcb_pkg::EN_A_STEP]   = q.step;
				end
				efcb_pkg::OFF_EN_B: begin
					d.rdata[efcb_pkg::EN_B_ADV]   = q.step_adv;
					d.rdata[efcb_pkg::EN_B_COMPR] = q.compr_req;
					d.rdata[efcb_pkg::EN_B_FSM]   = q.state_machine_engine_on;
				end
				efcb_pkg::OFF_PAGE_ADDR: begin
					d.rdata = q.pg_addr;
				end
				efcb_pkg::OFF_PAGE_DATA: begin
					d.rdata = page_read_i ? mem_rdata : q.pg_data;
				end
				efcb_pkg::OFF_FUNC_RT: begin
					d.rdata[efcb_pkg::RT_LC]   = q.lc_rt;
					d.rdata[efcb_pkg::RT_TILT] = q.incl_rt;
					d.rdata[efcb_pkg::RT_STEP] = q.step_rt;
				end
				efcb_pkg::OFF_FSM_RT_LO: begin
					d.rdata = q.fsm_rt_lo;
				end
				efcb_pkg::OFF_FSM_RT_HI: begin
					d.rdata = q.fsm_rt_hi;
				end
				default: begin
					d.rdata = efcb_pkg::RST_BYTE;
				end
			endcase
		end
		// Compression needs the runtime allow as well
		d.compr_on = q.compr_req & runtime_compression_allow_i;
		// Pin one follows the routed events
		d.pin = func_hit | fsm_hit;
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			q           <= '0;
			q.sel       <= efcb_pkg::RST_SEL;
			q.sigmot    <= efcb_pkg::RST_BIT;
			q.incline   <= efcb_pkg::RST_BIT;
			q.step      <= efcb_pkg::RST_BIT;
			q.step_adv  <= efcb_pkg::RST_BIT;
			q.compr_req <= efcb_pkg::RST_BIT;
			q.state_machine_engine_on    <= efcb_pkg::RST_BIT;
			q.pg_addr   <= efcb_pkg::RST_BYTE;
			q.pg_data   <= efcb_pkg::RST_BYTE;
			q.fsm_rt_lo <= efcb_pkg::RST_BYTE;
			q.fsm_rt_hi <= efcb_pkg::RST_BYTE;
			q.rdata     <= efcb_pkg::RST_BYTE;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign reg_rdata_o               = q.rdata;
	assign reg_ack_o                 = q.ack;
	assign page_select_o             = q.sel;
	assign sig_motion_on_o           = q.sigmot;
	assign incline_on_o              = q.incline;
	assign step_algorithm_on_o       = q.step;
	assign step_false_reject_on_o    = q.step_adv;
	assign buffer_compression_on_o   = q.compr_on;
	assign state_machine_engine_on_o = q.state_machine_engine_on;
	assign first_interrupt_pin_o     = q.pin;

	a_sel_write: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && acc_wr && at(reg_addr_i, efcb_pkg::OFF_PAGE_SEL)
		|=> page_select_o == $past(reg_wdata_i[7:4]))
		else $error("page selector did not take the written nibble");

	a_enable_a_write: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && acc_wr && at(reg_addr_i, efcb_pkg::OFF_EN_A)
		|=> {sig_motion_on_o, incline_on_o, step_algorithm_on_o}
			== $past(reg_wdata_i[5:3]))
		else $error("enable A bits not taken from write");

	a_engine_write: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && acc_wr && at(reg_addr_i, efcb_pkg::OFF_EN_B)
		|=> state_machine_engine_on_o == $past(reg_wdata_i[0])
			&& step_false_reject_on_o == $past(reg_wdata_i[4]))
		else $error("enable B bits not taken from write");

	a_compr_gate: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && !runtime_compression_allow_i |=> !buffer_compression_on_o)
		else $error("compression on without runtime allow");

	a_compr_follow: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && runtime_compression_allow_i && q.compr_req
		|=> buffer_compression_on_o)
		else $error("compression off although requested and allowed");

	a_locked_write: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && reg_wr_i && !reg_rd_i && !function_bank_access_on_i
		|=> $stable(q.sel) && $stable(q.fsm_rt_lo) && $stable(q.pg_addr)
			&& reg_ack_o && reg_rdata_o == 8'h00)
		else $error("write changed bank while access was off");

	a_gate_off: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && !function_events_route_gate_i [*2] |=> !first_interrupt_pin_o)
		else $error("pin one raised while route gate was off");

	a_machine_route: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && function_events_route_gate_i
		&& |(machine_evt_i & {q.fsm_rt_hi, q.fsm_rt_lo})
		|=> first_interrupt_pin_o)
		else $error("routed machine event missed pin one");

	a_timeout_route: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && function_events_route_gate_i && q.lc_rt && long_timeout_evt_i
		|=> first_interrupt_pin_o)
		else $error("routed long timeout missed pin one");

	a_pin_quiet: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && !(|(machine_evt_i & {q.fsm_rt_hi, q.fsm_rt_lo}))
		&& !(q.lc_rt && long_timeout_evt_i) && !(q.incl_rt && incline_evt_i)
		&& !(q.step_rt && step_evt_i) |=> !first_interrupt_pin_o)
		else $error("pin one raised with no routed event");

	a_page_readback: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && acc_wr && !acc_rd && at(reg_addr_i, efcb_pkg::OFF_PAGE_DATA)
		&& page_write_i ##1 ce_i && acc_rd && !acc_wr
		&& at(reg_addr_i, efcb_pkg::OFF_PAGE_DATA) && page_read_i
		&& $stable(q.sel) && $stable(q.pg_addr)
		|=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("page byte read back differs from write");

	a_incline_route: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && function_events_route_gate_i && q.incl_rt && incline_evt_i
		|=> first_interrupt_pin_o)
		else $error("routed incline event missed pin one");

	a_step_route: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && function_events_route_gate_i && q.step_rt && step_evt_i
		|=> first_interrupt_pin_o)
		else $error("routed step event missed pin one");

	a_locked_read: assert property (@(posedge clk_i)
		disable iff (!rst_n_q)
		ce_i && reg_rd_i && !function_bank_access_on_i
		|=> reg_ack_o && reg_rdata_o == 8'h00)
		else $error("read gave data while access was off");
endmodule : embedded_function_config_bank
`default_nettype wire

// File: dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       clk_i,
	output logic      [7:0] addr_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] wdata_o
);
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	function automatic logic [7:0] legal(input logic [7:0] a,
		input logic [7:0] d);
		case (a)
			efcb_pkg::OFF_PAGE_SEL: legal = {d[7:4], 4'h1};
			efcb_pkg::OFF_EN_A:     legal = d & 8'h38;
			efcb_pkg::OFF_EN_B:     legal = d & 8'h19;
			efcb_pkg::OFF_FUNC_RT:  legal = d & 8'h38;
			default:                legal = d;
		endcase
	endfunction : legal
	// Strobe held through the taking edge, left up for a following access
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		addr_o = a;
		wr_o = wr;
		rd_o = !wr;
		wdata_o = wr ? legal(a, d) : ~wdata_o;
		@(posedge clk_i);
		#1;
	endtask : acc
	// Released bus shows no stale value
	task automatic idle();
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
	endtask : idle
endmodule : host_model
`default_nettype wire

// File: dv/tb_embedded_function_config_bank.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; \
	if ((got) !== (ex)) begin err_count++; \
		$display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_embedded_function_config_bank;
	logic        clk, rstn, ce, acc_on, pg_wr, pg_rd, allow, gate;
	logic        lc, inc, stp, ack, pin, sigm, incl, step, adv, compr, fsm;
	logic [15:0] mev;
	logic [7:0]  addr, wdata, rdata, fr, lo, hi;
	logic        wr_s, rd_s;
	logic [3:0]  psel;
	logic [31:0] seed, ev;
	logic [7:0]  exq[$];
	logic [7:0]  e;
	logic        pin_x;
	int          err_count, n_checks, cyc;
	host_model host_u (.clk_i(clk), .addr_o(addr), .wr_o(wr_s),
		.rd_o(rd_s), .wdata_o(wdata));
	embedded_function_config_bank dut_u (.clk_i(clk), .rstn_i(rstn), .ce_i(ce),
		.reg_addr_i(addr), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .reg_ack_o(ack), .function_bank_access_on_i(acc_on),
		.page_write_i(pg_wr), .page_read_i(pg_rd),
		.runtime_compression_allow_i(allow),
		.function_events_route_gate_i(gate), .long_timeout_evt_i(lc),
		.incline_evt_i(inc), .step_evt_i(stp), .machine_evt_i(mev),
		.page_select_o(psel), .sig_motion_on_o(sigm), .incline_on_o(incl),
		.step_algorithm_on_o(step), .step_false_reject_on_o(adv),
		.buffer_compression_on_o(compr), .state_machine_engine_on_o(fsm),
		.first_interrupt_pin_o(pin));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		exq.push_back(8'h00);
		host_u.acc(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		exq.push_back(x);
		host_u.acc(1'b0, a, 8'h00);
	endtask : rd
	task automatic settle();
		host_u.idle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	// Each answer pairs with the oldest noted expectation
	always @(negedge clk) begin
		if (ack === 1'b1) begin
			e = (exq.size() > 0) ? exq.pop_front() : 8'hxx;
			`CHK("reg_rdata", e, rdata)
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		seed = 32'ha4f2dbf4;
		{rstn, acc_on, pg_wr, pg_rd, allow, gate, lc, inc, stp} = 9'h000;
		ce = 1'b1;
		mev = 16'h0000;
		repeat (5) @(posedge clk);
		#1;
		rstn = 1'b1;
		acc_on = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		`CHK("outputs", 10'h000, {psel,sigm,incl,step,adv,compr,fsm})
		rd(efcb_pkg::OFF_PAGE_SEL, 8'h01);
		rd(efcb_pkg::OFF_EN_A, 8'h00);
		rd(efcb_pkg::OFF_EN_B, 8'h00);
		rd(efcb_pkg::OFF_FUNC_RT, 8'h00);
		rd(efcb_pkg::OFF_FSM_RT_LO, 8'h00);
		rd(efcb_pkg::OFF_FSM_RT_HI, 8'h00);
		$display("test reset done");
		wr(efcb_pkg::OFF_EN_A, 8'h38);
		wr(efcb_pkg::OFF_EN_B, 8'h19);
		settle();
		`CHK("enables", 6'h3d, {sigm, incl, step, adv, compr, fsm})
		allow = 1'b1;
		settle();
		`CHK("compr", 1'b1, compr)
		wr(efcb_pkg::OFF_EN_A, 8'h08);
		wr(efcb_pkg::OFF_EN_B, 8'h10);
		rd(efcb_pkg::OFF_EN_A, 8'h08);
		settle();
		`CHK("enables", 6'h0c, {sigm, incl, step, adv, compr, fsm})
		$display("test enables done");
		acc_on = 1'b0;
		wr(efcb_pkg::OFF_EN_A, 8'h30);
		rd(efcb_pkg::OFF_EN_A, 8'h00);
		acc_on = 1'b1;
		wr(8'h03, 8'h55);
		rd(8'h03, 8'h00);
		rd(efcb_pkg::OFF_EN_A, 8'h08);
		settle();
		ce = 1'b0;
		host_u.acc(1'b1, efcb_pkg::OFF_EN_A, 8'h30);
		ce = 1'b1;
		rd(efcb_pkg::OFF_EN_A, 8'h08);
		settle();
		$display("test access done");
		fr = 8'(rnd());
		pg_wr = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(efcb_pkg::OFF_PAGE_SEL, {4'(i * 5), 4'h1});
			wr(efcb_pkg::OFF_PAGE_ADDR, fr);
			wr(efcb_pkg::OFF_PAGE_DATA, fr ^ 8'(i * 37 + 1));
		end
		pg_rd = 1'b1;
		rd(efcb_pkg::OFF_PAGE_DATA, fr ^ 8'h70);
		settle();
		`CHK("page_select", 4'hf, psel)
		pg_wr = 1'b0;
		pg_rd = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(efcb_pkg::OFF_PAGE_SEL, {4'(i * 5), 4'h1});
			rd(efcb_pkg::OFF_PAGE_DATA, fr ^ 8'(i * 37 + 1));
		end
		rd(efcb_pkg::OFF_PAGE_SEL, 8'hf1);
		settle();
		pg_rd = 1'b0;
		rd(efcb_pkg::OFF_PAGE_DATA, fr ^ 8'h70);
		settle();
		$display("test pages done");
		for (int i = 0; i < 40; i++) begin
			fr = 8'(rnd()) & 8'h38;
			lo = 8'(rnd() & rnd());
			hi = 8'(rnd() & rnd());
			wr(efcb_pkg::OFF_FUNC_RT, fr);
			wr(efcb_pkg::OFF_FSM_RT_LO, lo);
			wr(efcb_pkg::OFF_FSM_RT_HI, hi);
			rd(efcb_pkg::OFF_FUNC_RT, fr);
			ev = rnd() & rnd();
			gate = (i % 8) != 3;
			{lc, inc, stp} = ev[31:29];
			mev = ev[15:0] & 16'(rnd());
			settle();
			pin_x = gate & ((fr[5] & lc) | (fr[4] & inc) | (fr[3] & stp)
				| (|({hi, lo} & mev)));
			`CHK("int_pin", pin_x, pin)
		end
		$display("test routing done");
		repeat (3) @(posedge clk);
		`CHK("pending_answers", 0, exq.size())
		complete_run();
	end
endmodule : tb_embedded_function_config_bank
`default_nettype wire
